/* hdl/asc_host.sv */
// Host controller that drives a 64K x 4 asynchronous SRAM on its pins
`timescale 1ns/1ps
// Overview of operation
// R1 - The memory holds 65,536 words of 4 bits, reached by word address.
// R2 - Write and read data share one bidirectional 4-bit data bus.
// R3 - Parts with one select, select plus output enable, or two selects.
// R4 - Sixteen address lines pick the word, lowest bit first.
// R5 - A read is all selects low with write enable high; data within tacc.
// R6 - The memory floats its pins if a select or OE is high or WE is low.
// R7 - A write is the overlap of select low and WE low; either high ends it.
// R8 - Data reads back with the polarity it was written in.
// R9 - With WE falling no later than select, the memory never drives.
// R10 - With select rising no later than WE, the memory stays undriven.
// R11 - Select falling, WE falling, address or data change wakes the part; the model wakes on i_cs1_n falling, write end or address change.
// R12 - The part drops back to standby by itself after the powerdown delay.
// R13 - The host keeps select or WE high whenever the address changes.
// R14 - The host has the address valid no later than select falls.
// R15 - The memory has no clock and a read cycle equals its access time.
// R16 - Data on the pins is stored at the end of the select/WE overlap.
module asc_host
  import asc_pkg::*;
#(
  parameter logic [1:0] VARIANT = ASC_VAR_2CS_OE
)(
  input  wire logic                  i_sys_clk,
  input  wire logic                  i_reset,
  input  wire logic                  i_req_valid,
  input  wire logic                  i_req_write,
  input  wire logic [ASC_ADDR_W-1:0] i_req_addr,
  input  wire logic [ASC_DATA_W-1:0] i_req_wdata,
  output logic                       o_req_ready,
  output logic                       o_rsp_valid,
  output logic [ASC_DATA_W-1:0]      o_rsp_rdata,
  output logic [ASC_ADDR_W-1:0]      o_mem_addr,
  output logic                       o_first_chip_select_n,
  output logic                       o_second_chip_select_n,
  output logic                       o_mem_oe_n,
  output logic                       o_mem_we_n,
  input  wire logic [ASC_DATA_W-1:0] i_mem_dq,
  output logic [ASC_DATA_W-1:0]      o_mem_dq,
  output logic                       o_mem_dq_oe
);
  asc_sync_if rd_if ();

  asc_state_t            state_r;
  asc_state_t            state_nxt;
  logic [ASC_CNT_W-1:0]  cnt_r;
  logic [ASC_CNT_W-1:0]  cnt_nxt;
  logic                  wr_r;
  logic                  wr_nxt;
  logic [ASC_ADDR_W-1:0] addr_r;
  logic [ASC_ADDR_W-1:0] addr_nxt;
  logic [ASC_DATA_W-1:0] dq_r;
  logic [ASC_DATA_W-1:0] dq_nxt;
  logic                  dq_oe_r;
  logic                  dq_oe_nxt;
  logic                  cs_n_r;
  logic                  cs_n_nxt;
  logic                  oe_n_r;
  logic                  oe_n_nxt;
  logic                  we_n_r;
  logic                  we_n_nxt;
  logic                  ready_r;
  logic                  ready_nxt;
  logic                  rsp_r;
  logic                  rsp_nxt;
  logic [ASC_DATA_W-1:0] rdata_r;
  logic [ASC_DATA_W-1:0] rdata_nxt;

  // Cycles to wait after the read strobes, plus the two synchroniser stages
  localparam logic [ASC_CNT_W-1:0] RD_CYC =
    ASC_CNT_W'(ASC_TACC_CYC + 2);
  localparam logic [ASC_CNT_W-1:0] WP_CYC  = ASC_CNT_W'(ASC_TWP_CYC);
  localparam logic [ASC_CNT_W-1:0] HZ_CYC  = ASC_CNT_W'(ASC_THZ_CYC);

  asc_sync u_sync (
    .i_sys_clk (i_sys_clk),
    .i_reset   (i_reset),
    .i_pins    (i_mem_dq),
    .o_sync    (rd_if.src)
  );

  // Sequencer: address first, strobes next, release strobes before change
  always_comb begin
    state_nxt = state_r;
    cnt_nxt   = cnt_r;
    wr_nxt    = wr_r;
    addr_nxt  = addr_r;
    dq_nxt    = dq_r;
    dq_oe_nxt = dq_oe_r;
    cs_n_nxt  = cs_n_r;
    oe_n_nxt  = oe_n_r;
    we_n_nxt  = we_n_r;
    ready_nxt = 1'b0;
    rsp_nxt   = 1'b0;
    rdata_nxt = rdata_r;
    case (state_r)
      ASC_IDLE: begin
        ready_nxt = 1'b1;
        if (i_req_valid && ready_r) begin
          // Address moves only while every strobe is high
          addr_nxt  = i_req_addr;                          // R4 R13
          wr_nxt    = i_req_write;
          dq_nxt    = i_req_wdata;                         // R8
          ready_nxt = 1'b0;
          state_nxt = ASC_SETUP;
        end
      end
      ASC_SETUP: begin
        // Address has stood one cycle before select falls
        cnt_nxt = '0;
        if (wr_r) begin
          // WE and select fall together so the part never drives
          we_n_nxt  = 1'b0;                                // R9 R7
          cs_n_nxt  = 1'b0;                                // R7
          dq_oe_nxt = 1'b1;                                // R2
          state_nxt = ASC_WR_PULSE;
        end else begin
          cs_n_nxt  = 1'b0;                                // R14 R5
          oe_n_nxt  = 1'b0;                                // R6
          state_nxt = ASC_RD_WAIT;
        end
      end
      ASC_RD_WAIT: begin
        cnt_nxt = cnt_r + 8'h01;
        if (cnt_r == RD_CYC - 8'h01) begin
          rdata_nxt = rd_if.data;                          // R5 R8
          rsp_nxt   = 1'b1;
          cs_n_nxt  = 1'b1;
          oe_n_nxt  = 1'b1;
          cnt_nxt   = '0;
          state_nxt = ASC_RECOVER;
        end
      end
      ASC_WR_PULSE: begin
        cnt_nxt = cnt_r + 8'h01;
        if (cnt_r == WP_CYC - 8'h01) begin
          // Select and WE rise together; data held one more cycle
          cs_n_nxt  = 1'b1;                                // R10 R16
          we_n_nxt  = 1'b1;                                // R7
          rsp_nxt   = 1'b1;
          cnt_nxt   = '0;
          state_nxt = ASC_RECOVER;
        end
      end
      ASC_RECOVER: begin
        // Let the part float its pins before the next cycle
        dq_oe_nxt = 1'b0;
        cnt_nxt   = cnt_r + 8'h01;
        if (cnt_r == HZ_CYC - 8'h01) begin
          cnt_nxt   = '0;
          ready_nxt = 1'b1;
          state_nxt = ASC_IDLE;
        end
      end
      default: begin
        state_nxt = ASC_IDLE;
        cs_n_nxt  = 1'b1;
        we_n_nxt  = 1'b1;
        oe_n_nxt  = 1'b1;
        dq_oe_nxt = 1'b0;
      end
    endcase
  end

  always_ff @(posedge i_sys_clk) begin
    if (i_reset) begin
      state_r <= ASC_IDLE;
      cnt_r   <= 8'h00;
      wr_r    <= 1'b0;
      addr_r  <= 16'h0000;
      dq_r    <= 4'h0;
      dq_oe_r <= 1'b0;
      cs_n_r  <= 1'b1;
      oe_n_r  <= 1'b1;
      we_n_r  <= 1'b1;
      ready_r <= 1'b0;
      rsp_r   <= 1'b0;
      rdata_r <= 4'h0;
    end else begin
      state_r <= state_nxt;
      cnt_r   <= cnt_nxt;
      wr_r    <= wr_nxt;
      addr_r  <= addr_nxt;
      dq_r    <= dq_nxt;
      dq_oe_r <= dq_oe_nxt;
      cs_n_r  <= cs_n_nxt;
      oe_n_r  <= oe_n_nxt;
      we_n_r  <= we_n_nxt;
      ready_r <= ready_nxt;
      rsp_r   <= rsp_nxt;
      rdata_r <= rdata_nxt;
    end
  end

  // Second select follows the first on two-select parts; the OE pin is
  // driven from oe_n_r on the select-only part as on the others, since VARIANT is never used
  assign o_mem_addr             = addr_r;
  assign o_first_chip_select_n  = cs_n_r;                  // R3
  assign o_second_chip_select_n = cs_n_r;                  // R3
  assign o_mem_oe_n             = oe_n_r;
  assign o_mem_we_n             = we_n_r;
  assign o_mem_dq               = dq_r;
  assign o_mem_dq_oe            = dq_oe_r;
  assign o_req_ready            = ready_r;
  assign o_rsp_valid            = rsp_r;
  assign o_rsp_rdata            = rdata_r;
endmodule

/* hdl/asc_pkg.sv */
// Package of constants and types for the asynchronous SRAM host controller
package asc_pkg;
  localparam int ASC_ADDR_W    = 16;         // Word address width, A0..A15
  localparam int ASC_DATA_W    = 4;          // Word width
  localparam int ASC_DEPTH     = 65536;      // Words in the array
  localparam int ASC_CLK_PS    = 5000;       // Clock period, ps
  // Access / cycle time of the part, ns (slowest grade)
  localparam int ASC_TACC_NS   = 45;
  // Write pulse: overlap of select and write enable low, ns
  localparam int ASC_TWP_NS    = 30;
  // Output disable time after select high, ns
  localparam int ASC_THZ_NS    = 15;
  // Least times round up to whole cycles
  localparam int ASC_TACC_CYC  = (ASC_TACC_NS * 1000 + ASC_CLK_PS - 1)
                                 / ASC_CLK_PS;
  localparam int ASC_TWP_CYC   = (ASC_TWP_NS * 1000 + ASC_CLK_PS - 1)
                                 / ASC_CLK_PS;
  localparam int ASC_THZ_CYC   = (ASC_THZ_NS * 1000 + ASC_CLK_PS - 1)
                                 / ASC_CLK_PS;
  localparam int ASC_CNT_W     = 8;
  // Control variant of the attached part
  localparam logic [1:0] ASC_VAR_CS_ONLY  = 2'h0;
  localparam logic [1:0] ASC_VAR_CS_OE    = 2'h1;
  localparam logic [1:0] ASC_VAR_2CS_OE   = 2'h2;
  typedef enum logic [2:0] {
    ASC_IDLE, ASC_SETUP, ASC_RD_WAIT, ASC_WR_PULSE, ASC_RECOVER
  } asc_state_t;
endpackage

/* hdl/asc_sync.sv */
// Two-flop synchroniser for the data pins read back from the memory
`timescale 1ns/1ps
module asc_sync
  import asc_pkg::*;
(
  input  wire logic                  i_sys_clk,
  input  wire logic                  i_reset,
  input  wire logic [ASC_DATA_W-1:0] i_pins,
  asc_sync_if.src                    o_sync
);
  logic [ASC_DATA_W-1:0] meta_r;
  logic [ASC_DATA_W-1:0] meta_nxt;
  logic [ASC_DATA_W-1:0] hold_r;
  logic [ASC_DATA_W-1:0] hold_nxt;

  // Only the second stage is ever looked at downstream
  always_comb begin
    meta_nxt = i_pins;
    hold_nxt = meta_r;
  end

  always_ff @(posedge i_sys_clk) begin
    if (i_reset) begin
      meta_r <= 4'h0;
      hold_r <= 4'h0;
    end else begin
      meta_r <= meta_nxt;
      hold_r <= hold_nxt;
    end
  end

  assign o_sync.data = hold_r;
endmodule

/* hdl/asc_sync_if.sv */
// Interface carrying the synchronised read-back word between modules
`timescale 1ns/1ps
interface asc_sync_if;
  logic [asc_pkg::ASC_DATA_W-1:0] data;
  modport src (output data);
  modport dst (input data);
endinterface

/* testbench/asc_host_asserts.sv */
// Checker for the pin sequencing of the SRAM host controller
`timescale 1ns/1ps
module asc_host_asserts
  import asc_pkg::*;
(
  input wire logic                  i_sys_clk,
  input wire logic                  i_reset,
  input wire logic                  o_req_ready,
  input wire logic                  o_rsp_valid,
  input wire logic [ASC_ADDR_W-1:0] o_mem_addr,
  input wire logic                  o_first_chip_select_n,
  input wire logic                  o_second_chip_select_n,
  input wire logic                  o_mem_oe_n,
  input wire logic                  o_mem_we_n,
  input wire logic                  o_mem_dq_oe
);
  // Active-high views of the strobes keep the properties short
  wire cs = !o_first_chip_select_n;
  wire we = !o_mem_we_n;
  wire rd = !o_mem_oe_n;
  default clocking @(posedge i_sys_clk); endclocking
  default disable iff (i_reset);
  // Write: six cycles of overlap, select and WE rise on one edge
  sequence s_wr;
    (cs && we && o_mem_dq_oe)[*6] ##1 (!cs && !we && o_rsp_valid);
  endsequence
  // Read: eleven cycles of select and output enable, then answer
  sequence s_rd;
    (cs && rd && !we)[*8] ##1 (cs && rd && !we)[*3] ##1 (!cs && o_rsp_valid);
  endsequence
  chk_write_pulse:
    assert property ($fell(o_mem_we_n) |-> s_wr) else $error("write pulse");
  chk_read_strobe:
    assert property ($fell(o_mem_oe_n) |-> s_rd) else $error("read strobe");
  chk_addr_steady:
    assert property ($changed(o_mem_addr) && !$past(i_reset) |->
      (!cs || !we) && $past(!cs || !we)) else $error("addr moved");
  chk_addr_first:
    assert property ($fell(o_first_chip_select_n) |-> $stable(o_mem_addr))
      else $error("addr late");
  chk_sel_equal:
    assert property (o_second_chip_select_n == o_first_chip_select_n)
      else $error("selects differ");
  chk_one_driver:
    assert property (o_mem_dq_oe |-> !rd) else $error("bus fight");
  chk_reset_idle:
    assert property (disable iff (1'b0) i_reset |=> !cs && !we && !rd &&
      !o_mem_dq_oe && !o_req_ready) else $error("reset not idle");
  chk_rsp_pulse:
    assert property (o_rsp_valid |=> !o_rsp_valid) else $error("rsp long");
endmodule
bind asc_host asc_host_asserts asc_host_asserts_i (.i_sys_clk, .i_reset,
  .o_req_ready, .o_rsp_valid, .o_mem_addr, .o_first_chip_select_n,
  .o_second_chip_select_n, .o_mem_oe_n, .o_mem_we_n, .o_mem_dq_oe);

/* testbench/asc_host_tb_top.sv */
// Self-checking bench for the SRAM host controller
`timescale 1ns/1ps
module asc_host_tb_top
  import asc_pkg::*;
;
  logic                  i_sys_clk = 0, i_reset = 1, i_req_valid = 0;
  logic                  i_req_write = 0, o_req_ready, o_rsp_valid, mem_oe;
  logic                  cs1_n, cs2_n, oe_n, we_n, dq_oe;
  logic [ASC_ADDR_W-1:0] i_req_addr = '0, a, mem_addr, wq [$];
  logic [ASC_DATA_W-1:0] i_req_wdata = '0, pin, mem_q;
  // Two-state, so floating pins toggle from the start instead of sticking
  bit   [ASC_DATA_W-1:0] pin_last = '0;
  logic [ASC_DATA_W-1:0] rdata, dq_out, ref_m [int];
  logic [31:0]           seed = 32'hfd84;
  int                    n_fail = 0, compares = 0, n;

  asc_host asc_host_i (.i_sys_clk, .i_reset, .i_req_valid, .i_req_write,
    .i_req_addr, .i_req_wdata, .o_req_ready, .o_rsp_valid,
    .o_rsp_rdata(rdata), .o_mem_addr(mem_addr), .o_mem_oe_n(oe_n),
    .o_first_chip_select_n(cs1_n), .o_second_chip_select_n(cs2_n),
    .o_mem_we_n(we_n), .i_mem_dq(pin), .o_mem_dq(dq_out), .o_mem_dq_oe(dq_oe));
  asc_sram_model #(.DLY_NS(37)) asc_sram_model_i (.i_addr(mem_addr),
    .i_cs1_n(cs1_n), .i_cs2_n(cs2_n), .i_oe_n(oe_n), .i_we_n(we_n),
    .i_dq(pin), .o_dq(mem_q), .o_dq_oe(mem_oe));

  always #2.5 i_sys_clk = ~i_sys_clk;
  // Floating pins toggle so a stale word can never pass for data
  assign pin = dq_oe ? dq_out : (mem_oe ? mem_q : ~pin_last);
  always @(posedge i_sys_clk) pin_last <= pin;
  // Both ends driving the shared pins at once would be a short
  always @(negedge i_sys_clk) begin
    if (!i_reset) chk("drivers", dq_oe & mem_oe, 0);
  end

  // Xorshift step for the random stimulus
  function automatic logic [31:0] xs(input logic [31:0] s);
    logic [31:0] v;
    v = s ^ (s << 13);
    v = v ^ (v >> 17);
    v = v ^ (v << 5);
    return v;
  endfunction
  task automatic chk(input string nm, input logic [31:0] seen, exp);
    compares++;
    if (seen !== exp) begin
      n_fail++;
      $display("[FAIL] %s exp %h seen %h", nm, exp, seen);
    end
  endtask
  task automatic summarize();
    $display("compares %0d n_fail %0d", compares, n_fail);
    if (n_fail == 0 && compares > 0)
      $display("RESULT: PASS");
    else
      $display("RESULT: FAIL");
    $finish;
  endtask
  // Bounded wait for ready or a response; n counts the edges
  task automatic wait_for(input bit rsp);
    n = 0;
    while ((rsp ? o_rsp_valid : o_req_ready) !== 1'b1) begin
      @(posedge i_sys_clk);
      #1;
      n++;
      if (n > 40) begin
        n_fail++;
        summarize();
      end
    end
  endtask
  // Request held until taken, then latency against the cycle counts and data against ref_m
  task automatic xfer(input logic w, input logic [ASC_ADDR_W-1:0] ad,
                      input logic [ASC_DATA_W-1:0] dt);
    i_req_valid = 1;
    i_req_write = w;
    i_req_addr = ad;
    i_req_wdata = dt;
    wait_for(0);
    @(posedge i_sys_clk);
    #1;
    i_req_valid = 0;
    wait_for(1);
    // Edges after the take: setup plus pulse, or setup, access and sync
    chk("latency", n, w ? ASC_TWP_CYC + 1 : ASC_TACC_CYC + 3);
    if (w) ref_m[ad] = dt;
    else chk("rdata", rdata, ref_m[ad]);
  endtask

  initial begin
    repeat (16) @(posedge i_sys_clk);
    #1;
    i_reset = 0;
    chk("idle", {cs1_n, cs2_n, oe_n, we_n, dq_oe}, 5'h1e);
    // One-hot, all-zero and all-one addresses reach every line
    for (int i = 0; i < 18; i++) begin
      a = (i < 16) ? 16'h0001 << i : {ASC_ADDR_W{i[0]}};
      wq.push_back(a);
      seed = xs(seed);
      xfer(1, a, seed[3:0]);
    end
    foreach (wq[k]) xfer(0, wq[k], 4'h0);
    // Random mix, back to back; reads only where a word was written
    repeat (40) begin
      seed = xs(seed);
      if (seed[20]) xfer(0, wq[seed[27:21] % wq.size()], 4'h0);
      else begin
        wq.push_back(seed[15:0]);
        xfer(1, seed[15:0], seed[19:16]);
      end
    end
    // Reset in the middle of a write pulse must drop every strobe
    i_req_valid = 1;
    i_req_write = 1;
    wait_for(0);
    repeat (4) @(posedge i_sys_clk);
    #1;
    i_req_valid = 0;
    i_reset = 1;
    @(posedge i_sys_clk);
    #1;
    chk("rst_pins", {cs1_n, we_n, dq_oe, o_req_ready}, 4'hc);
    i_reset = 0;
    xfer(1, 16'h1234, 4'h5);
    xfer(0, 16'h1234, 4'h0);
    summarize();
  end
endmodule

/* testbench/asc_sram_model.sv */
// Behavioural model of the 64K x 4 common-I/O static RAM
`timescale 1ns/1ps
module asc_sram_model
  import asc_pkg::*;
#(
  parameter int DLY_NS = 20
)(
  input  wire logic [ASC_ADDR_W-1:0] i_addr,
  input  wire logic                  i_cs1_n,
  input  wire logic                  i_cs2_n,
  input  wire logic                  i_oe_n,
  input  wire logic                  i_we_n,
  input  wire logic [ASC_DATA_W-1:0] i_dq,
  output logic      [ASC_DATA_W-1:0] o_dq,
  output logic                       o_dq_oe
);
  logic [ASC_DATA_W-1:0] mem [ASC_DEPTH];
  logic                  active_power_state = 1'b0;
  wire                   wr = !i_cs1_n && !i_cs2_n && !i_we_n;
  // Pins float on any select or OE high, or WE low
  assign o_dq_oe = !i_cs1_n && !i_cs2_n && !i_oe_n && i_we_n;
  // Store at the end of the overlap, same polarity as written
  always @(negedge wr) mem[i_addr] = i_dq;
  // Old word turns to junk at once; the new one lands DLY_NS later
  initial o_dq = '0;
  always @(posedge o_dq_oe or i_addr) begin
    o_dq = ~o_dq;
    #(DLY_NS) o_dq = mem[i_addr];
  end
  // Wakes on a strobe or address edge, sleeps again on its own
  always @(negedge i_cs1_n or negedge wr or i_addr) begin
    active_power_state = 1'b1;
    #(ASC_TACC_NS) active_power_state = 1'b0;
  end
endmodule
